// ==== nvs_pkg.sv ====
// Constants and types for the shadow RAM host controller
// Notes on behaviour
// - Write: host presents address, then data, with select and enable low.
// - Host may start a write from standby: enable low first, then select.
// - Host holds recall strobe low at least 300 ns.
// - No read until 1100 ns after recall strobe rises, or after 1400 ns low.
// - Host holds store strobe low at least 200 ns.
package nvs_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 4;
    localparam int CLK_MHZ = 200;
    localparam int T_SETUP_NS = 50;
    localparam int T_WP_NS = 150;
    localparam int T_WR_NS = 25;
    localparam int T_RD_NS = 300;
    localparam int T_STP_NS = 200;
    localparam int T_RCL_PULSE_NS = 300;
    localparam int T_RCL_CYCLE_NS = 1400;
    localparam int T_ARC_NS = 1100;
    localparam int T_STC_MS = 10;
    // Least times round up, at least one cycle
    localparam int C_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int C_WP = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int C_WR = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RD = (T_RD_NS * CLK_MHZ + 999) / 1000;
    localparam int C_STP = (T_STP_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RCL_PULSE = (T_RCL_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RCL_CYCLE = (T_RCL_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int C_ARC = (T_ARC_NS * CLK_MHZ + 999) / 1000;
    localparam int C_STC = T_STC_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [1:0] {
        NVS_CMD_READ,
        NVS_CMD_WRITE,
        NVS_CMD_STORE,
        NVS_CMD_RECALL
    } nvs_cmd_t;
endpackage : nvs_pkg

// ==== nvs_pin_if.sv ====
// Pin group shared between the sequencer and the pin driver
`timescale 1ns/10ps
interface nvs_pin_if;
    logic                      sel;
    logic                      wr;
    logic                      store;
    logic                      recall;
    logic                      drive;
    logic [nvs_pkg::ADDR_W-1:0] addr;
    logic [nvs_pkg::DATA_W-1:0] wdata;
    modport seq (output sel, wr, store, recall, drive, addr, wdata);
    modport pins (input sel, wr, store, recall, drive, addr, wdata);
endinterface : nvs_pin_if

// ==== nvs_pin_reg.sv ====
// Output flops for the device pins
`timescale 1ns/10ps
module nvs_pin_reg (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset,
    nvs_pin_if.pins                         pin,
    output logic                            o_cs_n,
    output logic                            o_we_n,
    output logic                            o_store_n,
    output logic                            o_recall_n,
    output logic [nvs_pkg::ADDR_W-1:0]      o_word_address,
    output logic [nvs_pkg::DATA_W-1:0]      o_data_pins_out,
    output logic                            o_data_pins_oe
);
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_cs_n          <= 1'b1;
            o_we_n          <= 1'b1;
            o_store_n       <= 1'b1;
            o_recall_n      <= 1'b1;
            o_word_address  <= '0;
            o_data_pins_out <= '0;
            o_data_pins_oe  <= 1'b0;
        end else begin
            o_cs_n          <= ~pin.sel;
            o_we_n          <= ~pin.wr;
            o_store_n       <= ~pin.store;
            o_recall_n      <= ~pin.recall;
            o_word_address  <= pin.addr;
            o_data_pins_out <= pin.wdata;
            o_data_pins_oe  <= pin.drive;
        end
    end
endmodule : nvs_pin_reg

// ==== nvs_host.sv ====
// Host controller sequencing reads, writes, store and recall
`timescale 1ns/10ps
module nvs_host #(
    parameter int STORE_CYCLES = nvs_pkg::C_STC
) (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_req_valid,
    input  wire nvs_pkg::nvs_cmd_t          i_req_cmd,
    input  wire logic [nvs_pkg::ADDR_W-1:0] i_req_addr,
    input  wire logic [nvs_pkg::DATA_W-1:0] i_req_wdata,
    input  wire logic                       i_recall_full,
    input  wire logic [nvs_pkg::DATA_W-1:0] i_data_pins_in,
    output logic                            o_req_ready,
    output logic                            o_rsp_valid,
    output logic [nvs_pkg::DATA_W-1:0]      o_rsp_rdata,
    output logic                            o_cs_n,
    output logic                            o_we_n,
    output logic                            o_store_n,
    output logic                            o_recall_n,
    output logic [nvs_pkg::ADDR_W-1:0]      o_word_address,
    output logic [nvs_pkg::DATA_W-1:0]      o_data_pins_out,
    output logic                            o_data_pins_oe
);
    typedef enum logic [2:0] {
        NVS_IDLE,
        NVS_RD,
        NVS_WR_SETUP,
        NVS_WR_PULSE,
        NVS_WR_REC,
        NVS_ST_PULSE,
        NVS_RC_PULSE,
        NVS_BUSY
    } nvs_state_t;

    localparam logic [nvs_pkg::CNT_W-1:0] K_SETUP     =
        nvs_pkg::CNT_W'(nvs_pkg::C_SETUP);
    localparam logic [nvs_pkg::CNT_W-1:0] K_WP        =
        nvs_pkg::CNT_W'(nvs_pkg::C_WP);
    localparam logic [nvs_pkg::CNT_W-1:0] K_WR        =
        nvs_pkg::CNT_W'(nvs_pkg::C_WR);
    localparam logic [nvs_pkg::CNT_W-1:0] K_RD        =
        nvs_pkg::CNT_W'(nvs_pkg::C_RD);
    localparam logic [nvs_pkg::CNT_W-1:0] K_STP       =
        nvs_pkg::CNT_W'(nvs_pkg::C_STP);
    localparam logic [nvs_pkg::CNT_W-1:0] K_RCL_PULSE =
        nvs_pkg::CNT_W'(nvs_pkg::C_RCL_PULSE);
    localparam logic [nvs_pkg::CNT_W-1:0] K_RCL_CYCLE =
        nvs_pkg::CNT_W'(nvs_pkg::C_RCL_CYCLE);
    localparam logic [nvs_pkg::CNT_W-1:0] K_ARC       =
        nvs_pkg::CNT_W'(nvs_pkg::C_ARC);
    localparam logic [nvs_pkg::CNT_W-1:0] K_STC       =
        nvs_pkg::CNT_W'(STORE_CYCLES);

    nvs_state_t                  state;
    logic [nvs_pkg::CNT_W-1:0]   cnt;
    logic                        rd_last;
    logic                        rsp_valid;
    logic [nvs_pkg::DATA_W-1:0]  rsp_rdata;
    logic                        req_ready;
    nvs_pin_if                   pin ();

    function automatic logic is_last(input logic [nvs_pkg::CNT_W-1:0] c,
                                     input logic [nvs_pkg::CNT_W-1:0] k);
        return c >= k - 1'b1;
    endfunction : is_last

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= NVS_IDLE;
            cnt   <= '0;
        end else begin
            unique case (state)
                NVS_IDLE: begin
                    cnt <= '0;
                    if (i_req_valid) begin
                        unique case (i_req_cmd)
                            nvs_pkg::NVS_CMD_READ:   state <= NVS_RD;
                            nvs_pkg::NVS_CMD_WRITE:  state <= NVS_WR_SETUP;
                            nvs_pkg::NVS_CMD_STORE:  state <= NVS_ST_PULSE;
                            nvs_pkg::NVS_CMD_RECALL: state <= NVS_RC_PULSE;
                        endcase
                    end
                end
                NVS_RD: begin
                    cnt <= cnt + 1'b1;
                    if (is_last(cnt, K_RD)) begin
                        state <= NVS_IDLE;
                    end
                end
                NVS_WR_SETUP: begin
                    cnt <= cnt + 1'b1;
                    if (is_last(cnt, K_SETUP)) begin
                        state <= NVS_WR_PULSE;
                        cnt   <= '0;
                    end
                end
                NVS_WR_PULSE: begin
                    cnt <= cnt + 1'b1;
                    if (is_last(cnt, K_WP)) begin
                        state <= NVS_WR_REC;
                        cnt   <= '0;
                    end
                end
                NVS_WR_REC: begin
                    cnt <= cnt + 1'b1;
                    if (is_last(cnt, K_WR)) begin
                        state <= NVS_IDLE;
                    end
                end
                NVS_ST_PULSE: begin
                    cnt <= cnt + 1'b1;
                    if (is_last(cnt, K_STP)) begin
                        state <= NVS_BUSY;
                        cnt   <= K_STC - K_STP;
                    end
                end
                NVS_RC_PULSE: begin
                    cnt <= cnt + 1'b1;
                    if (i_recall_full ? is_last(cnt, K_RCL_CYCLE)
                                      : is_last(cnt, K_RCL_PULSE)) begin
                        state <= i_recall_full ? NVS_IDLE : NVS_BUSY;
                        cnt   <= i_recall_full ? '0 : K_ARC;
                    end
                end
                NVS_BUSY: begin
                    // Device gives no busy flag; wait out its time
                    cnt <= cnt - 1'b1;
                    if (cnt <= 1) begin
                        state <= NVS_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels for the next cycle
    always_comb begin
        pin.sel    = (state == NVS_RD) || (state == NVS_WR_PULSE);
        pin.wr     = (state == NVS_WR_SETUP) || (state == NVS_WR_PULSE)
                   || (state == NVS_WR_REC);
        pin.store  = (state == NVS_ST_PULSE);
        pin.recall = (state == NVS_RC_PULSE);
        pin.drive  = (state == NVS_WR_PULSE);
    end

    // Address and data are held between accesses
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pin.addr  <= '0;
            pin.wdata <= '0;
        end else if (state == NVS_IDLE && i_req_valid) begin
            pin.addr  <= i_req_addr;
            pin.wdata <= i_req_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request and answer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state == NVS_IDLE) && !i_req_valid;
        end
    end

    // Pins are sampled one edge after the read phase ends, while select
    // is still low, so the full access time has passed since it fell
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rd_last   <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rd_last   <= (state == NVS_RD) && is_last(cnt, K_RD);
            rsp_valid <= rd_last;
            if (rd_last) begin
                rsp_rdata <= i_data_pins_in;
            end
        end
    end

    assign o_req_ready = req_ready;
    assign o_rsp_valid = rsp_valid;
    assign o_rsp_rdata = rsp_rdata;

    nvs_pin_reg u_pin_reg (
        .i_sys_clk       (i_sys_clk),
        .i_reset         (i_reset),
        .pin             (pin),
        .o_cs_n          (o_cs_n),
        .o_we_n          (o_we_n),
        .o_store_n       (o_store_n),
        .o_recall_n      (o_recall_n),
        .o_word_address  (o_word_address),
        .o_data_pins_out (o_data_pins_out),
        .o_data_pins_oe  (o_data_pins_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb_chk @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    a_store_pulse_len: assert property (
        $fell(o_store_n) |-> !o_store_n [*8])
        else $error("store strobe too short");
    a_recall_pulse_len: assert property (
        $fell(o_recall_n) |-> !o_recall_n [*8])
        else $error("recall strobe too short");
    a_strobe_excl: assert property (
        !(!o_store_n && !o_recall_n))
        else $error("both strobes low");
    a_no_drive_nv: assert property (
        (!o_store_n || !o_recall_n) |-> !o_data_pins_oe)
        else $error("data driven during transfer");
    a_drive_with_sel: assert property (
        o_data_pins_oe |-> (!o_cs_n && !o_we_n))
        else $error("data driven outside write");
    a_we_before_cs: assert property (
        ($fell(o_cs_n) && !o_we_n) |-> !$past(o_we_n))
        else $error("select fell before write enable");
    a_access_strobes: assert property (
        !o_cs_n |-> (o_store_n && o_recall_n))
        else $error("access during transfer");
    a_store_wait: assert property (
        $rose(o_store_n) |-> ##1 !o_req_ready [*8])
        else $error("ready too soon after store");
    a_rsp_after_read: assert property (
        o_rsp_valid |-> !$past(o_cs_n))
        else $error("read data taken after select rose");
endmodule : nvs_host

// ==== nvs_dev_model.sv ====
// Behavioural model of the shadowed 64x4 nonvolatile RAM
`timescale 1ns/10ps
module nvs_dev_model #(
    parameter int   RECALL_NS = 300,
    parameter int   STORE_NS  = 400,
    parameter logic SUPPLY_OK = 1'b1
) (
    input  wire logic       i_cs_n,
    input  wire logic       i_we_n,
    input  wire logic       i_store_n,
    input  wire logic       i_recall_n,
    input  wire logic [5:0] i_word_address,
    input  wire logic [3:0] i_data_pins,
    output logic [3:0]      o_data_pins,
    output logic            o_data_pins_oe
);
    logic [3:0] ram [64];
    logic [3:0] nv [64];
    logic       busy_store;
    logic       busy_recall;
    logic       wr_act;
    logic [3:0] d_dly;
    logic [5:0] a_dly;
    ////////////////////////////////////////////////////////////////////////
    // Power-up contents and automatic recall
    initial begin
        busy_store = 1'b0;
        busy_recall = 1'b0;
        for (int i = 0; i < 64; i++) begin
            nv[i] = 4'(i) ^ 4'h5;
            ram[i] = nv[i];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Nonvolatile transfers
    always @(negedge i_recall_n) begin
        if (!busy_store) begin
            busy_recall = 1'b1;
            for (int i = 0; i < 64; i++) ram[i] = nv[i];
            #(RECALL_NS);
            busy_recall = 1'b0;
        end
    end
    always @(negedge i_store_n) begin
        if (!busy_recall && i_recall_n && SUPPLY_OK) begin
            busy_store = 1'b1;
            for (int i = 0; i < 64; i++) nv[i] = ram[i];
            #(STORE_NS);
            busy_store = 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Static RAM access
    assign #1 d_dly = i_data_pins;
    assign #1 a_dly = i_word_address;
    assign wr_act = !i_cs_n && !i_we_n && i_store_n && i_recall_n
                    && !busy_store && !busy_recall;
    always @(negedge wr_act) begin
        if (i_store_n) ram[a_dly] = d_dly;
        else ram[a_dly] = 4'hx;
    end
    assign o_data_pins = ram[i_word_address];
    assign o_data_pins_oe = !i_cs_n && i_we_n && i_store_n && i_recall_n
                            && !busy_store && !busy_recall;
endmodule : nvs_dev_model

// ==== nv_shadow_sram_64x4_tb.sv ====
// Self-checking bench for the shadow RAM host controller
`timescale 1ns/10ps
module nv_shadow_sram_64x4_tb;
    logic              i_sys_clk;
    logic              i_reset;
    logic              req_valid;
    nvs_pkg::nvs_cmd_t req_cmd;
    logic [5:0]        req_addr;
    logic [3:0]        req_wdata;
    logic              recall_full;
    logic              req_ready;
    logic              rsp_valid;
    logic [3:0]        rsp_rdata;
    logic              cs_n, we_n, store_n, recall_n, host_oe, dev_oe;
    logic [5:0]        word_address;
    logic [3:0]        host_out, dev_out, wire_data, last_data;
    int                error_cnt;
    int                n_tests;
    int                rc_gap;
    nvs_host #(.STORE_CYCLES(100)) dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req_valid(req_valid),
        .i_req_cmd(req_cmd), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .i_recall_full(recall_full), .i_data_pins_in(wire_data),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
        .o_rsp_rdata(rsp_rdata), .o_cs_n(cs_n), .o_we_n(we_n),
        .o_store_n(store_n), .o_recall_n(recall_n),
        .o_word_address(word_address), .o_data_pins_out(host_out),
        .o_data_pins_oe(host_oe));
    nvs_dev_model dev (
        .i_cs_n(cs_n), .i_we_n(we_n), .i_store_n(store_n),
        .i_recall_n(recall_n), .i_word_address(word_address),
        .i_data_pins(wire_data), .o_data_pins(dev_out),
        .o_data_pins_oe(dev_oe));
    // Undriven bus shows a toggling pattern
    assign wire_data = host_oe ? host_out : (dev_oe ? dev_out : ~last_data);
    always @(posedge i_sys_clk) last_data <= wire_data;
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic req(nvs_pkg::nvs_cmd_t c, logic [5:0] a, logic [3:0] d,
                       logic [3:0] exp);
        int n;
        n = 0;
        @(negedge i_sys_clk);
        while (req_ready !== 1'b1 && n < 4000) begin
            n++;
            @(negedge i_sys_clk);
        end
        if (n >= 4000) begin
            error_cnt++;
            $display("[ERR] ready expected 1 seen %b", req_ready);
            conclude();
        end
        @(posedge i_sys_clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        req_wdata <= d;
        @(posedge i_sys_clk);
        req_valid <= 1'b0;
        if (c == nvs_pkg::NVS_CMD_READ) begin
            n = 0;
            @(negedge i_sys_clk);
            while (rsp_valid !== 1'b1 && n < 200) begin
                n++;
                @(negedge i_sys_clk);
            end
            if (n >= 200) begin
                error_cnt++;
                $display("[ERR] rsp_valid expected 1 seen %b", rsp_valid);
                conclude();
            end
            chk("read data", exp, rsp_rdata);
        end
    endtask : req
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_powerup();
        req(nvs_pkg::NVS_CMD_READ, 6'h00, 4'h0, 4'h5);
        req(nvs_pkg::NVS_CMD_READ, 6'h3f, 4'h0, 4'ha);
        $display("Test powerup done");
    endtask : t_powerup
    task automatic t_write_read();
        req(nvs_pkg::NVS_CMD_WRITE, 6'h00, 4'hc, 4'h0);
        req(nvs_pkg::NVS_CMD_WRITE, 6'h3f, 4'h3, 4'h0);
        req(nvs_pkg::NVS_CMD_READ, 6'h00, 4'h0, 4'hc);
        req(nvs_pkg::NVS_CMD_READ, 6'h3f, 4'h0, 4'h3);
        req(nvs_pkg::NVS_CMD_READ, 6'h15, 4'h0, 4'h0);
        $display("Test write_read done");
    endtask : t_write_read
    task automatic t_store_recall();
        req(nvs_pkg::NVS_CMD_WRITE, 6'h07, 4'h3, 4'h0);
        req(nvs_pkg::NVS_CMD_STORE, 6'h00, 4'h0, 4'h0);
        req(nvs_pkg::NVS_CMD_WRITE, 6'h07, 4'h9, 4'h0);
        req(nvs_pkg::NVS_CMD_READ, 6'h07, 4'h0, 4'h9);
        req(nvs_pkg::NVS_CMD_RECALL, 6'h00, 4'h0, 4'h0);
        req(nvs_pkg::NVS_CMD_READ, 6'h07, 4'h0, 4'h3);
        $display("Test store_recall done");
    endtask : t_store_recall
    task automatic t_recall_full();
        @(posedge i_sys_clk);
        recall_full <= 1'b1;
        req(nvs_pkg::NVS_CMD_WRITE, 6'h3f, 4'he, 4'h0);
        req(nvs_pkg::NVS_CMD_RECALL, 6'h00, 4'h0, 4'h0);
        req(nvs_pkg::NVS_CMD_READ, 6'h3f, 4'h0, 4'h3);
        $display("Test recall_full done");
    endtask : t_recall_full
    ////////////////////////////////////////////////////////////////////////
    // Bus watch: device floats while idle, storing or recalling
    always @(negedge i_sys_clk) begin
        if (!i_reset && dev_oe === 1'b1 && (recall_n !== 1'b1
            || store_n !== 1'b1 || cs_n !== 1'b0 || host_oe !== 1'b0)) begin
            error_cnt++;
            $display("[ERR] bus owner expected host seen device");
        end
        if (!i_reset && host_oe === 1'b1 && (dev_oe !== 1'b0
            || cs_n !== 1'b0 || we_n !== 1'b0 || store_n !== 1'b1
            || recall_n !== 1'b1)) begin
            error_cnt++;
            $display("[ERR] host drive expected write seen cs %b we %b",
                     cs_n, we_n);
        end
        if (!i_reset && cs_n === 1'b0 && we_n === 1'b1
            && recall_full !== 1'b1 && rc_gap < nvs_pkg::C_ARC) begin
            error_cnt++;
            $display("[ERR] recall gap expected %0d seen %0d",
                     nvs_pkg::C_ARC, rc_gap);
        end
    end
    // Cycles since the recall strobe last rose
    always @(posedge i_sys_clk) begin
        if (i_reset) rc_gap <= nvs_pkg::C_ARC;
        else if (recall_n !== 1'b1) rc_gap <= 0;
        else if (rc_gap < nvs_pkg::C_ARC) rc_gap <= rc_gap + 1;
    end
    initial begin
        error_cnt = 0;
        n_tests = 0;
        i_reset = 1'b1;
        req_valid = 1'b0;
        req_cmd = nvs_pkg::NVS_CMD_READ;
        req_addr = 6'h00;
        req_wdata = 4'h0;
        recall_full = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        t_powerup();
        t_write_read();
        t_store_recall();
        t_recall_full();
        conclude();
    end
endmodule : nv_shadow_sram_64x4_tb
